//--- vtc_pkg.sv
// Purpose: Shared constants and types for vector stream termination control
// Assumes: Operation codes are eight bits wide
// Notes:   Stream index 0 is source A, 1 is source B, 2 is the result stream
package vtc_pkg;

    localparam int unsigned NUM_STREAMS = 3;
    localparam int unsigned STREAM_A    = 0;
    localparam int unsigned STREAM_B    = 1;
    localparam int unsigned STREAM_C    = 2;
    localparam int unsigned LEN_W_DFLT  = 16;

    // Two-source vector codes extended with machine zero
    localparam logic [7:0] OP_VZ_FIRST  = 8'h80;
    localparam logic [7:0] OP_VZ_LAST   = 8'h87;
    localparam logic [7:0] OP_VZ_X0     = 8'h94;
    localparam logic [7:0] OP_VZ_X1     = 8'h95;
    localparam logic [7:0] OP_VZ_X2     = 8'h9B;
    // Two-source vector codes extended with normalized one
    localparam logic [7:0] OP_VN_0      = 8'h88;
    localparam logic [7:0] OP_VN_1      = 8'h89;
    localparam logic [7:0] OP_VN_2      = 8'h8B;
    localparam logic [7:0] OP_VN_3      = 8'h8C;
    localparam logic [7:0] OP_VN_4      = 8'h8F;
    // Single-source vector codes
    localparam logic [7:0] OP_VS_FIRST  = 8'h90;
    localparam logic [7:0] OP_VS_MID    = 8'h93;
    localparam logic [7:0] OP_VS_SECOND = 8'h96;
    localparam logic [7:0] OP_VS_LAST   = 8'h9A;
    localparam logic [7:0] OP_VS_X0     = 8'h9C;
    // Sparse vector codes
    localparam logic [7:0] OP_SV_0      = 8'hA0;
    localparam logic [7:0] OP_SV_1      = 8'hA1;
    localparam logic [7:0] OP_SV_2      = 8'hA2;
    localparam logic [7:0] OP_SV_3      = 8'hA4;
    localparam logic [7:0] OP_SV_4      = 8'hA5;
    localparam logic [7:0] OP_SV_5      = 8'hA6;
    localparam logic [7:0] OP_SV_6      = 8'hA8;
    localparam logic [7:0] OP_SV_7      = 8'hA9;
    localparam logic [7:0] OP_SV_8      = 8'hAB;
    localparam logic [7:0] OP_SV_9      = 8'hAC;
    localparam logic [7:0] OP_SV_10     = 8'hAF;

    typedef enum logic [1:0] {
        EXT_MACHINE_ZERO,
        EXT_NORM_ONE,
        EXT_ZERO_BIT
    } ext_kind_t;

    typedef enum logic {
        ST_IDLE,
        ST_RUN
    } vtc_state_t;

endpackage

//--- stream_len_counter.sv
// Purpose: Remaining-length counter for one operand stream
// Assumes: Decrement requests while empty are ignored
// Notes:   Empty flag is combinational from the count register
`timescale 1ns/1ps
`default_nettype none
module stream_len_counter #(
    parameter int unsigned LEN_W = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic             load,
    input  wire logic [LEN_W-1:0] load_len,
    input  wire logic             dec,
    output logic      [LEN_W-1:0] count_q,
    output logic                  empty
);

    logic [LEN_W-1:0] count_d;
    logic             last;

    assign empty   = (count_q == '0);
    assign last    = (count_q == LEN_W'(1));
    // Saturate at zero so an exhausted source keeps reporting empty
    assign count_d = load           ? load_len :
                     (dec & ~empty) ? count_q - LEN_W'(1) : count_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    logic unused_last;
    assign unused_last = last;

endmodule
`default_nettype wire

//--- vector_termination_control.sv
// Purpose: Per-instruction stream end, extension and no-op decisions
// Assumes: Issue logic and streaming datapath share sys_clk and rst_n
// Notes:   One element per elem_step; datapath may stall by holding it low
//
// Overview of operation
// - Exhausted governing length before first fetch makes a no-op, no flags touched.
// - Sparse operations end when the result order vector is used up.
// - Zero result designator or zero result length makes a sparse no-op.
// - Short or empty sparse source order vectors are padded with zero bits.
// - Codes 80-87, 94, 95, 9B extend sources with machine zero.
// - Codes 88, 89, 8B, 8C, 8F extend sources with normalized one.
// - Single-source codes use stream A only, machine-zero extended.
// - Optional control vector gates result position writes for every code.
`timescale 1ns/1ps
`default_nettype none
module vector_termination_control #(
    parameter int unsigned LEN_W = vtc_pkg::LEN_W_DFLT
) (
    input  wire logic                sys_clk,
    input  wire logic                rst_n,
    // Issue side
    input  wire logic                start,
    input  wire logic [7:0]          opcode,
    input  wire logic [LEN_W-1:0]    len_a,
    input  wire logic [LEN_W-1:0]    len_b,
    input  wire logic [LEN_W-1:0]    len_c,
    input  wire logic                result_desig_zero,
    input  wire logic                ctl_vec_en,
    output logic                     start_ready,
    // Streaming datapath side
    input  wire logic                elem_step,
    input  wire logic                ctl_vec_bit,
    output logic                     busy,
    output logic                     fetch_a,
    output logic                     fetch_b,
    output logic                     extend_a,
    output logic                     extend_b,
    output logic                     result_write,
    output logic                     flags_enable,
    output vtc_pkg::ext_kind_t       ext_kind_q,
    output logic [LEN_W-1:0]         elem_pos_q,
    output logic                     done_q,
    output logic                     noop_q,
    output logic                     reject_q
);

    vtc_pkg::vtc_state_t state_q;
    vtc_pkg::vtc_state_t state_d;
    vtc_pkg::ext_kind_t  ext_kind_d;

    logic             op_vz;
    logic             op_vn;
    logic             op_vs;
    logic             op_sv;
    logic             op_known;
    logic             accept;
    logic             go_noop;
    logic             go_run;
    logic             step_run;
    logic             finish;
    logic             b_used_q;
    logic             b_used_d;
    logic             cv_en_q;
    logic             cv_en_d;
    logic             done_d;
    logic             noop_d;
    logic             reject_d;
    logic [LEN_W-1:0] elem_pos_d;
    logic             res_last;

    logic [LEN_W-1:0] load_len [vtc_pkg::NUM_STREAMS];
    logic [LEN_W-1:0] count_q  [vtc_pkg::NUM_STREAMS];
    logic             empty    [vtc_pkg::NUM_STREAMS];
    // Source streams only; the result stream is never extended
    logic             src_used   [vtc_pkg::STREAM_C];
    logic             src_fetch  [vtc_pkg::STREAM_C];
    logic             src_extend [vtc_pkg::STREAM_C];

    // Opcode class decode
    assign op_vz = ((opcode >= vtc_pkg::OP_VZ_FIRST) && (opcode <= vtc_pkg::OP_VZ_LAST))
                 || (opcode == vtc_pkg::OP_VZ_X0)
                 || (opcode == vtc_pkg::OP_VZ_X1)
                 || (opcode == vtc_pkg::OP_VZ_X2);
    assign op_vn = (opcode == vtc_pkg::OP_VN_0)
                 || (opcode == vtc_pkg::OP_VN_1)
                 || (opcode == vtc_pkg::OP_VN_2)
                 || (opcode == vtc_pkg::OP_VN_3)
                 || (opcode == vtc_pkg::OP_VN_4);
    assign op_vs = ((opcode >= vtc_pkg::OP_VS_FIRST) && (opcode <= vtc_pkg::OP_VS_MID))
                 || ((opcode >= vtc_pkg::OP_VS_SECOND) && (opcode <= vtc_pkg::OP_VS_LAST))
                 || (opcode == vtc_pkg::OP_VS_X0);
    assign op_sv = (opcode == vtc_pkg::OP_SV_0)
                 || (opcode == vtc_pkg::OP_SV_1)
                 || (opcode == vtc_pkg::OP_SV_2)
                 || (opcode == vtc_pkg::OP_SV_3)
                 || (opcode == vtc_pkg::OP_SV_4)
                 || (opcode == vtc_pkg::OP_SV_5)
                 || (opcode == vtc_pkg::OP_SV_6)
                 || (opcode == vtc_pkg::OP_SV_7)
                 || (opcode == vtc_pkg::OP_SV_8)
                 || (opcode == vtc_pkg::OP_SV_9)
                 || (opcode == vtc_pkg::OP_SV_10);
    assign op_known = op_vz | op_vn | op_vs | op_sv;

    // Start handling
    assign start_ready = (state_q == vtc_pkg::ST_IDLE);
    assign accept      = start & start_ready & op_known;
    // Result designator is only meaningful for sparse codes; there a zero designator
    // makes a no-op whatever the length, and other codes ignore it
    assign go_noop     = accept & ((len_c == '0)
                                   | (op_sv & result_desig_zero));
    assign go_run      = accept & ~go_noop;

    // Streams and their counters
    assign load_len[vtc_pkg::STREAM_A] = len_a;
    assign load_len[vtc_pkg::STREAM_B] = op_vs ? '0 : len_b;
    assign load_len[vtc_pkg::STREAM_C] = len_c;

    assign step_run = (state_q == vtc_pkg::ST_RUN) & elem_step;

    // Counters load only on a real run; a no-op start leaves them, and the
    // data flags, exactly as the previous instruction left them
    for (genvar s = 0; s < vtc_pkg::NUM_STREAMS; s++) begin : g_stream
        stream_len_counter #(
            .LEN_W    (LEN_W)
        ) u_cnt (
            .sys_clk  (sys_clk),
            .rst_n    (rst_n),
            .load     (go_run),
            .load_len (load_len[s]),
            .dec      (step_run),
            .count_q  (count_q[s]),
            .empty    (empty[s])
        );
    end

    // Result stream governs the end; source state is irrelevant to it
    assign res_last = (count_q[vtc_pkg::STREAM_C] == LEN_W'(1));
    assign finish   = step_run & res_last;

    // Per-element source handling: fetch while data remains, extend after.
    // An empty source is padded rather than ending the run, so a short
    // operand never cuts the result stream short.
    assign busy = (state_q == vtc_pkg::ST_RUN);
    assign src_used[vtc_pkg::STREAM_A] = 1'b1;
    assign src_used[vtc_pkg::STREAM_B] = b_used_q;
    for (genvar s = 0; s < vtc_pkg::STREAM_C; s++) begin : g_src
        assign src_fetch[s]  = busy & src_used[s] & ~empty[s];
        assign src_extend[s] = busy & src_used[s] & empty[s];
    end
    assign fetch_a  = src_fetch[vtc_pkg::STREAM_A];
    assign extend_a = src_extend[vtc_pkg::STREAM_A];
    assign fetch_b  = src_fetch[vtc_pkg::STREAM_B];
    assign extend_b = src_extend[vtc_pkg::STREAM_B];

    // Control vector bit comes with the element from the same clock domain
    assign result_write = busy & (~cv_en_q | ctl_vec_bit);
    // No-op paths never pass through RUN, so flags stay untouched
    assign flags_enable = busy;

    // Next-state selection
    // Start is only looked at in IDLE, so a start while running is ignored and raises no reject_q
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            vtc_pkg::ST_IDLE: begin
                if (go_run) begin
                    state_d = vtc_pkg::ST_RUN;
                end
            end
            vtc_pkg::ST_RUN: begin
                if (finish) begin
                    state_d = vtc_pkg::ST_IDLE;
                end
            end
        endcase
    end
    assign ext_kind_d = ~go_run ? ext_kind_q :
                        op_sv   ? vtc_pkg::EXT_ZERO_BIT :
                        op_vn   ? vtc_pkg::EXT_NORM_ONE :
                                  vtc_pkg::EXT_MACHINE_ZERO;
    assign b_used_d   = go_run ? ~op_vs : b_used_q;
    assign cv_en_d    = go_run ? ctl_vec_en : cv_en_q;
    // Position restarts with each run so the datapath can index the result
    assign elem_pos_d = go_run   ? '0 :
                        step_run ? elem_pos_q + LEN_W'(1) : elem_pos_q;
    assign done_d     = finish;
    assign noop_d     = go_noop;
    // Unknown codes are refused so that other logic can handle them
    assign reject_d   = start & start_ready & ~op_known;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= vtc_pkg::ST_IDLE;
            ext_kind_q <= vtc_pkg::EXT_MACHINE_ZERO;
            b_used_q   <= 1'b0;
            cv_en_q    <= 1'b0;
        end else begin
            state_q    <= state_d;
            ext_kind_q <= ext_kind_d;
            b_used_q   <= b_used_d;
            cv_en_q    <= cv_en_d;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            elem_pos_q <= '0;
            done_q     <= 1'b0;
            noop_q     <= 1'b0;
            reject_q   <= 1'b0;
        end else begin
            elem_pos_q <= elem_pos_d;
            done_q     <= done_d;
            noop_q     <= noop_d;
            reject_q   <= reject_d;
        end
    end

endmodule
`default_nettype wire

//--- vtc_monitor.sv
// Purpose: Checks on stream end, extension and no-op outputs
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound to the top module after endmodule
`timescale 1ns/1ps
`default_nettype none
module vtc_monitor #(
    parameter int unsigned LEN_W = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic             start,
    input  wire logic             start_ready,
    input  wire logic             result_desig_zero,
    input  wire logic             ctl_vec_en,
    input  wire logic             elem_step,
    input  wire logic             ctl_vec_bit,
    input  wire logic             busy,
    input  wire logic             fetch_b,
    input  wire logic             extend_b,
    input  wire logic             result_write,
    input  wire logic             done_q,
    input  wire logic             noop_q,
    input  wire logic [7:0]       opcode,
    input  wire logic [LEN_W-1:0] len_c,
    input  wire logic [LEN_W-1:0] elem_pos_q,
    input  wire logic [1:0]       ext_kind_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_take(logic [7:0] op); start && start_ready && opcode == op; endsequence
    sequence s_go(logic [7:0] op); s_take(op) ##0 len_c != 0 && !result_desig_zero; endsequence
    sequence s_last(logic [7:0] op); s_go(op) ##0 len_c == 1 ##1 elem_step; endsequence
    property p_noop; s_take(8'h87) ##0 len_c == 0 |=> noop_q && !busy; endproperty
    a_noop: assert property (p_noop) else $error("vector no-op missed");
    property p_sv; s_take(8'hA0) ##0 result_desig_zero |=> noop_q && !busy; endproperty
    a_sv: assert property (p_sv) else $error("sparse no-op missed");
    property p_norm; s_go(8'h88) |=> ext_kind_q == vtc_pkg::EXT_NORM_ONE; endproperty
    a_norm: assert property (p_norm) else $error("wrong extension kind");
    property p_one; s_go(8'h9C) |=> busy && !fetch_b && !extend_b; endproperty
    a_one: assert property (p_one) else $error("second source used");
    property p_pad; s_go(8'hA0) |=> ext_kind_q == vtc_pkg::EXT_ZERO_BIT; endproperty
    a_pad: assert property (p_pad) else $error("sparse padding kind wrong");
    // Only the first element is tied here; later ones are judged by the bench
    property p_gate; s_go(8'h80) ##0 ctl_vec_en |=> result_write == ctl_vec_bit; endproperty
    a_gate: assert property (p_gate) else $error("result write not gated");
    property p_end; s_last(8'hA0) |=> done_q && !busy; endproperty
    a_end: assert property (p_end) else $error("sparse run did not end");
    property p_pos; busy && elem_step ##1 busy |-> elem_pos_q == $past(elem_pos_q) + 1'b1;
    endproperty
    a_pos: assert property (p_pos) else $error("element position not advanced");
endmodule
bind vector_termination_control vtc_monitor #(.LEN_W(LEN_W)) vtc_monitor_i (
    .sys_clk, .rst_n, .start, .start_ready, .result_desig_zero, .ctl_vec_en, .elem_step,
    .ctl_vec_bit, .busy, .fetch_b, .extend_b, .result_write, .done_q, .noop_q, .opcode,
    .len_c, .elem_pos_q, .ext_kind_q);
`default_nettype wire

//--- stream_datapath_model.sv
// Purpose: Streaming datapath stand-in that consumes result elements
// Assumes: Drives its outputs on the falling edge
// Notes:   Slow mode stalls every other cycle
`timescale 1ns/1ps
`default_nettype none
module stream_datapath_model (
    input  wire logic sys_clk,
    input  wire logic busy,
    input  wire logic slow,
    output var logic  elem_step,
    output var logic  ctl_vec_bit
);
    logic [1:0] tick_q = 2'h0;
    // Mask pattern runs out of step with the stalls, so both values are consumed
    always @(negedge sys_clk) begin
        tick_q <= tick_q + 2'h1;
        elem_step <= busy && (!slow || tick_q[0]);
        ctl_vec_bit <= ^tick_q;
    end
endmodule
`default_nettype wire

//--- vector_termination_control_tb.sv
// Purpose: Self-checking bench for vector stream termination control
// Assumes: Bench plays the issuer, a model plays the datapath
// Notes:   Inputs change on the falling clock edge
`timescale 1ns/1ps
`default_nettype none
module vector_termination_control_tb;
    logic               sys_clk = 1'b0, rst_n = 1'b0, start = 1'b0, slow = 1'b0;
    logic               result_desig_zero = 1'b0, ctl_vec_en = 1'b0;
    logic [7:0]         opcode = 8'h00;
    logic [15:0]        len_a = 16'h0000, len_b = 16'h0000, len_c = 16'h0000, elem_pos_q;
    logic               start_ready, elem_step, ctl_vec_bit, busy, flags_enable, fetch_a;
    logic               fetch_b, extend_a, extend_b, result_write, done_q, noop_q, reject_q;
    vtc_pkg::ext_kind_t ext_kind_q;
    int                 err_total = 0, cmp_count = 0;
    wire logic [4:0]    outs = {fetch_a, extend_a, fetch_b, extend_b, result_write};
    vector_termination_control #(.LEN_W(16)) vector_termination_control_i (
        .sys_clk, .rst_n, .start, .opcode, .len_a, .len_b, .len_c, .result_desig_zero,
        .ctl_vec_en, .start_ready, .elem_step, .ctl_vec_bit, .busy, .fetch_a, .fetch_b,
        .extend_a, .extend_b, .result_write, .flags_enable, .ext_kind_q, .elem_pos_q,
        .done_q, .noop_q, .reject_q);
    stream_datapath_model stream_datapath_model_i (
        .sys_clk, .busy, .slow, .elem_step, .ctl_vec_bit);
    initial forever #4 sys_clk = ~sys_clk;
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(string w, logic [15:0] e, logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic issue(logic [7:0] op, logic [15:0] a, b, c, logic dz, cv);
        @(negedge sys_clk);
        {opcode, len_a, len_b, len_c, result_desig_zero, ctl_vec_en} = {op, a, b, c, dz, cv};
        start = 1'b1;
        @(negedge sys_clk);
        start = 1'b0;
        #1;
    endtask
    task automatic t_noop(logic [7:0] op, logic dz);
        issue(op, 16'h0002, 16'h0002, 16'h0000, dz, 1'b0);
        chk("noop_q", 16'h0001, {15'h0000, noop_q});
        chk("busy_flags", 16'h0000, {14'h0000, busy, flags_enable});
        $display("No-op test %h finished", op);
    endtask
    task automatic t_reject(logic [7:0] op);
        issue(op, 16'h0001, 16'h0001, 16'h0001, 1'b0, 1'b0);
        chk("reject_q", 16'h0001, {15'h0000, reject_q});
        chk("busy_noop", 16'h0000, {14'h0000, busy, noop_q});
        $display("Reject test %h finished", op);
    endtask
    task automatic t_run(logic [7:0] op, logic [15:0] a, b, c, logic two, cv, logic [1:0] kind);
        int         k = 0, n;
        logic [4:0] x;
        issue(op, a, b, c, 1'b0, cv);
        chk("ext_kind_q", {14'h0000, kind}, {14'h0000, ext_kind_q});
        chk("ready_flags", 16'h0001, {14'h0000, start_ready, flags_enable});
        for (n = 0; n < 300 && done_q !== 1'b1; n++) begin
            if (busy === 1'b1) begin
                chk("elem_pos_q", k[15:0], elem_pos_q);
                x = {k < a, k >= a, two && k < b, two && k >= b, !cv || ctl_vec_bit};
                chk("outs", {11'h000, x}, {11'h000, outs});
                if (elem_step === 1'b1) k++;
            end
            @(negedge sys_clk);
            #1;
        end
        chk("done_q", 16'h0001, {15'h0000, done_q});
        chk("ready_flags", 16'h0002, {14'h0000, start_ready, flags_enable});
        if (done_q !== 1'b1) close_out();
        chk("steps", c, k[15:0]);
        $display("Run test %h finished", op);
    endtask
    initial begin
        repeat (10) @(negedge sys_clk);
        rst_n = 1'b1;
        t_noop(8'h87, 1'b0);
        t_noop(8'hA0, 1'b1);
        t_reject(8'h8A);
        t_reject(8'hA3);
        t_run(8'h80, 16'h0001, 16'h0000, 16'h0003, 1'b1, 1'b1, 2'h0);
        t_run(8'h9C, 16'h0001, 16'h0005, 16'h0002, 1'b0, 1'b0, 2'h0);
        t_run(8'hA0, 16'h0000, 16'h0001, 16'h0003, 1'b1, 1'b0, 2'h2);
        t_run(8'hA0, 16'h0003, 16'h0003, 16'h0001, 1'b1, 1'b0, 2'h2);
        slow = 1'b1;
        t_run(8'h88, 16'h0002, 16'h0003, 16'h0003, 1'b1, 1'b1, 2'h1);
        close_out();
    end
endmodule
`default_nettype wire
